// ==== icsh_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module icsh_ctrl
  import icsh_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // register port
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // input monitors and select pins
  input  wire logic [3:0]        signal_loss_alarm,
  input  wire logic [3:0]        frequency_out_of_range_alarm,
  input  wire logic [1:0]        select_pins,
  // measured frequency of the selected input
  input  wire logic [FREQ_W-1:0] freq_sample,
  input  wire logic              freq_sample_valid,
  // status and configuration
  output logic      [1:0]        active_input_indicator,
  output logic                   holdover_active,
  output logic      [FREQ_W-1:0] holdover_freq,
  output icsh_cfg_s              cfg
);

  logic [4:0]        avg_len_reg;
  logic [4:0]        hist_delay_reg;
  logic              force_hold_reg;
  logic [1:0]        policy_reg;
  logic [7:0]        masks_reg;
  logic [2:0]        rank_reg [4];
  logic              sel_regctrl_reg;
  logic [1:0]        sel_field_reg;
  icsh_cfg_s         cfg_reg;
  logic [1:0]        active_reg;
  logic              hold_reg;
  logic [FREQ_W-1:0] hold_freq_reg;
  logic [7:0]        rdata_reg;

  // register writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avg_len_reg     <= RST_AVG_LENGTH;
      hist_delay_reg  <= RST_HIST_DELAY;
      force_hold_reg  <= 1'b0;
      policy_reg      <= RST_POLICY;
      masks_reg       <= RST_ALARM_MASKS;
      rank_reg[0]     <= RST_RANK0;
      rank_reg[1]     <= RST_RANK1;
      rank_reg[2]     <= RST_RANK2;
      rank_reg[3]     <= RST_RANK3;
      sel_regctrl_reg <= 1'b0;
      sel_field_reg   <= 2'h0;
      cfg_reg         <= '{input_buffer_enable: RST_INPUT_BUFFER[3:0], default: '0};
    end else if (reg_wr) begin
      // writes to the read-only status byte match no branch and are dropped
      if (reg_addr == OFS_AVG_LENGTH) begin
        avg_len_reg <= reg_wdata[4:0];
      end else if (reg_addr == OFS_HIST_DELAY) begin
        hist_delay_reg <= reg_wdata[4:0];
      end else if (reg_addr == OFS_FORCE_HOLD) begin
        force_hold_reg <= reg_wdata[0];
      end else if (reg_addr == OFS_SWITCH_CTRL) begin
        policy_reg                    <= reg_wdata[1:0];
        cfg_reg.phase_buildout_enable <= reg_wdata[2];
      end else if (reg_addr == OFS_ALARM_MASKS) begin
        masks_reg <= reg_wdata;
      end else if (reg_addr == OFS_PRIO_01) begin
        rank_reg[0] <= reg_wdata[2:0];
        rank_reg[1] <= reg_wdata[6:4];
      end else if (reg_addr == OFS_PRIO_23) begin
        rank_reg[2] <= reg_wdata[2:0];
        rank_reg[3] <= reg_wdata[6:4];
      end else if (reg_addr == OFS_INPUT_SELECT) begin
        sel_regctrl_reg <= reg_wdata[0];
        sel_field_reg   <= reg_wdata[2:1];
      end else if (reg_addr == OFS_REF_SOURCE) begin
        cfg_reg.reference_external_source <= reg_wdata[0];
      end else if (reg_addr == OFS_IO_VOLTAGE) begin
        cfg_reg.interface_voltage_high <= reg_wdata[0];
      end else if (reg_addr == OFS_INPUT_BUFFER) begin
        cfg_reg.input_buffer_enable <= reg_wdata[3:0];
        cfg_reg.pulsed_cmos_enable  <= reg_wdata[7:4];
      end else if (reg_addr == OFS_DIV_ROUTING) begin
        cfg_reg.divider_route <= reg_wdata[1:0];
      end
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == OFS_ACTIVE_INPUT) begin
        rdata_reg <= {active_reg, 6'h00};
      end else if (reg_addr == OFS_AVG_LENGTH) begin
        rdata_reg <= {3'h0, avg_len_reg};
      end else if (reg_addr == OFS_HIST_DELAY) begin
        rdata_reg <= {3'h0, hist_delay_reg};
      end else if (reg_addr == OFS_FORCE_HOLD) begin
        rdata_reg <= {7'h00, force_hold_reg};
      end else if (reg_addr == OFS_SWITCH_CTRL) begin
        rdata_reg <= {5'h00, cfg_reg.phase_buildout_enable, policy_reg};
      end else if (reg_addr == OFS_ALARM_MASKS) begin
        rdata_reg <= masks_reg;
      end else if (reg_addr == OFS_PRIO_01) begin
        rdata_reg <= {1'b0, rank_reg[1], 1'b0, rank_reg[0]};
      end else if (reg_addr == OFS_PRIO_23) begin
        rdata_reg <= {1'b0, rank_reg[3], 1'b0, rank_reg[2]};
      end else if (reg_addr == OFS_INPUT_SELECT) begin
        rdata_reg <= {5'h00, sel_field_reg, sel_regctrl_reg};
      end else if (reg_addr == OFS_REF_SOURCE) begin
        rdata_reg <= {7'h00, cfg_reg.reference_external_source};
      end else if (reg_addr == OFS_IO_VOLTAGE) begin
        rdata_reg <= {7'h00, cfg_reg.interface_voltage_high};
      end else if (reg_addr == OFS_INPUT_BUFFER) begin
        rdata_reg <= {cfg_reg.pulsed_cmos_enable, cfg_reg.input_buffer_enable};
      end else if (reg_addr == OFS_DIV_ROUTING) begin
        rdata_reg <= {6'h00, cfg_reg.divider_route};
      end else begin
        // unmapped reads return zero rather than the last byte
        rdata_reg <= 8'h00;
      end
    end
  end

  // pin synchronisers: a bit changes once stages two and three agree
  // reset clears to the idle levels, so no false alarm follows reset
  logic [9:0] pin_s1_reg;
  logic [9:0] pin_s2_reg;
  logic [9:0] pin_s3_reg;
  logic [9:0] pin_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= 10'h000;
      pin_s2_reg <= 10'h000;
      pin_s3_reg <= 10'h000;
      pin_reg    <= 10'h000;
    end else begin
      pin_s1_reg <= {select_pins, frequency_out_of_range_alarm, signal_loss_alarm};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_reg    <= (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));
    end
  end

  // availability of each input
  // rank codes above the lowest priority are reserved and never chosen by the automatic policies
  logic [3:0] avail;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_avail
      assign avail[gi] = cfg_reg.input_buffer_enable[gi]
                       && rank_reg[gi] != 3'h0 && rank_reg[gi] <= RANK_LOWEST
                       && !(pin_reg[gi] && !masks_reg[gi])
                       && !(pin_reg[gi+4] && !masks_reg[gi+4]);
    end
  endgenerate

  // lowest rank wins, strict compare keeps the lower index on a tie
  function automatic logic [1:0] best_input(input logic [3:0] av,
                                            input logic [11:0] ranks);
    logic [1:0] best;
    logic [2:0] best_rank;
    best      = 2'h0;
    best_rank = 3'h7;
    for (int i = 0; i < 4; i++) begin
      if (av[i] && ranks[3*i +: 3] < best_rank) begin
        best      = 2'(i);
        best_rank = ranks[3*i +: 3];
      end
    end
    return best;
  endfunction

  logic [1:0]   best;
  logic         any_avail;
  icsh_policy_e policy;
  assign best      = best_input(avail, {rank_reg[3], rank_reg[2], rank_reg[1], rank_reg[0]});
  assign any_avail = |avail;
  assign policy    = icsh_policy_e'(policy_reg);

  // selection and holdover state
  logic [FREQ_W-1:0] avg_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_reg <= 2'h0;
    end else begin
      case (policy)
        ICSH_AUTO_NONREVERT: begin
          // stays put while its input is good; holdover exit counts as a loss
          if (any_avail && !(avail[active_reg] && !hold_reg)) begin
            active_reg <= best;
          end
        end
        ICSH_AUTO_REVERT: begin
          if (any_avail) begin
            active_reg <= best;
          end
        end
        default: begin
          // reserved policy code falls back to manual
          active_reg <= sel_regctrl_reg ? sel_field_reg : pin_reg[9:8];
        end
      endcase
    end
  end

  // manual mode holds over only when forced: a chosen input is never
  // dropped because of alarms that manual selection ignores
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= force_hold_reg
               || ((policy == ICSH_AUTO_NONREVERT || policy == ICSH_AUTO_REVERT)
                   && !any_avail);
    end
  end

  // holdover frequency
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_freq_reg <= '0;
    end else if (!hold_reg) begin
      // tracks the average so the value frozen on entry is the last one
      hold_freq_reg <= avg_reg;
    end
  end

  // frequency history; samples stop while in holdover so the history
  // keeps describing the last good reference
  logic [FREQ_W-1:0]  hist_mem [2**HIST_AW];
  logic [HIST_AW-1:0] wptr_reg;
  always_ff @(posedge clock) begin
    if (freq_sample_valid && !hold_reg) begin
      hist_mem[wptr_reg] <= freq_sample;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wptr_reg <= '0;
    end else if (freq_sample_valid && !hold_reg) begin
      wptr_reg <= wptr_reg + 1'b1;
    end
  end

  // window of 2**min(length,5) samples, ending delay samples before newest
  // the window slides while it is summed; a sample landing mid-window shifts
  // the older end by one, a small error traded for no second buffer
  logic [2:0]         avg_log;
  logic [4:0]         win_last;
  logic [4:0]         cnt_reg;
  logic [SUM_W-1:0]   sum_reg;
  logic [HIST_AW-1:0] rd_idx;
  assign avg_log  = (avg_len_reg > 5'(MAX_AVG_LOG)) ? MAX_AVG_LOG : avg_len_reg[2:0];
  assign win_last = 5'((6'h01 << avg_log) - 6'h01);
  assign rd_idx   = wptr_reg - 6'h01 - {1'b0, hist_delay_reg} - {1'b0, cnt_reg};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= 5'h00;
      sum_reg <= '0;
      avg_reg <= '0;
    end else if (cnt_reg >= win_last) begin
      avg_reg <= FREQ_W'((sum_reg + SUM_W'(hist_mem[rd_idx])) >> avg_log);
      sum_reg <= '0;
      cnt_reg <= 5'h00;
    end else begin
      sum_reg <= sum_reg + SUM_W'(hist_mem[rd_idx]);
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  assign reg_rdata              = rdata_reg;
  assign active_input_indicator = active_reg;
  assign holdover_active        = hold_reg;
  assign holdover_freq          = hold_freq_reg;
  assign cfg                    = cfg_reg;

endmodule
`default_nettype wire

// ==== icsh_pkg.sv ====
`default_nettype none
package icsh_pkg;
  // register offsets
  localparam logic [15:0] OFS_ACTIVE_INPUT = 16'h0507;
  localparam logic [15:0] OFS_INPUT_SELECT = 16'h052A;
  localparam logic [15:0] OFS_AVG_LENGTH   = 16'h052E;
  localparam logic [15:0] OFS_HIST_DELAY   = 16'h052F;
  localparam logic [15:0] OFS_FORCE_HOLD   = 16'h0535;
  localparam logic [15:0] OFS_SWITCH_CTRL  = 16'h0536;
  localparam logic [15:0] OFS_ALARM_MASKS  = 16'h0537;
  localparam logic [15:0] OFS_PRIO_01      = 16'h0538;
  localparam logic [15:0] OFS_PRIO_23      = 16'h0539;
  localparam logic [15:0] OFS_REF_SOURCE   = 16'h090E;
  localparam logic [15:0] OFS_IO_VOLTAGE   = 16'h0943;
  localparam logic [15:0] OFS_INPUT_BUFFER = 16'h0949;
  localparam logic [15:0] OFS_DIV_ROUTING  = 16'h0A03;
  // reset values
  localparam logic [4:0] RST_AVG_LENGTH   = 5'h00;
  localparam logic [4:0] RST_HIST_DELAY   = 5'h00;
  localparam logic [1:0] RST_POLICY       = 2'h0;
  localparam logic [7:0] RST_ALARM_MASKS  = 8'h00;
  localparam logic [2:0] RST_RANK0        = 3'h1;
  localparam logic [2:0] RST_RANK1        = 3'h2;
  localparam logic [2:0] RST_RANK2        = 3'h3;
  localparam logic [2:0] RST_RANK3        = 3'h4;
  localparam logic [7:0] RST_INPUT_BUFFER = 8'h0F;
  localparam logic [2:0] RANK_LOWEST      = 3'h4;
  // history buffer and averaging
  localparam int         FREQ_W      = 16;
  localparam int         HIST_AW     = 6;
  localparam int         SUM_W       = FREQ_W + 5;
  localparam logic [2:0] MAX_AVG_LOG = 3'h5;

  typedef enum logic [1:0] {
    ICSH_MANUAL,
    ICSH_AUTO_NONREVERT,
    ICSH_AUTO_REVERT,
    ICSH_RESERVED
  } icsh_policy_e;

  typedef struct packed {
    logic       phase_buildout_enable;
    logic [3:0] input_buffer_enable;
    logic [3:0] pulsed_cmos_enable;
    logic       reference_external_source;
    logic       interface_voltage_high;
    logic [1:0] divider_route;
  } icsh_cfg_s;
endpackage
`default_nettype wire

// ==== icsh_ctrl_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module icsh_ctrl_chk
  import icsh_pkg::*;
(
  // clock and register port
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // status
  input wire logic        holdover_active,
  input wire logic [15:0] holdover_freq,
  input wire icsh_cfg_s   cfg
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  // the force bit lands in its register first, holdover follows one edge later
  chk_force_enters: assert property (
    reg_wr && reg_addr == OFS_FORCE_HOLD && reg_wdata[0] |=> ##1 holdover_active)
    else $error("force bit did not enter holdover");
  chk_freq_frozen: assert property (
    holdover_active && $past(holdover_active) |-> $stable(holdover_freq))
    else $error("holdover frequency moved in holdover");
  chk_pbo_copy: assert property (
    reg_wr && reg_addr == OFS_SWITCH_CTRL
    |=> cfg.phase_buildout_enable == $past(reg_wdata[2]))
    else $error("phase buildout bit not taken");
  chk_buffer_copy: assert property (
    reg_wr && reg_addr == OFS_INPUT_BUFFER
    |=> {cfg.pulsed_cmos_enable, cfg.input_buffer_enable} == $past(reg_wdata))
    else $error("input buffer bits not taken");
  chk_ref_copy: assert property (
    reg_wr && reg_addr == OFS_REF_SOURCE
    |=> cfg.reference_external_source == $past(reg_wdata[0]))
    else $error("reference source bit not taken");
  chk_io_copy: assert property (
    reg_wr && reg_addr == OFS_IO_VOLTAGE
    |=> cfg.interface_voltage_high == $past(reg_wdata[0]))
    else $error("interface voltage bit not taken");
  chk_route_copy: assert property (
    reg_wr && reg_addr == OFS_DIV_ROUTING
    |=> cfg.divider_route == $past(reg_wdata[1:0]))
    else $error("divider route not taken");
  chk_cfg_quiet: assert property (!reg_wr |=> $stable(cfg))
    else $error("configuration changed without a write");
  cover property (holdover_active ##1 !holdover_active);
  cover property (reg_wr && reg_addr == OFS_SWITCH_CTRL);
  cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind icsh_ctrl icsh_ctrl_chk chk_u (.clock(clock), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .holdover_active(holdover_active), .holdover_freq(holdover_freq), .cfg(cfg));
`default_nettype wire

// ==== icsh_ref_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module icsh_ref_model
  import icsh_pkg::*;
(
  // clock and scenario controls
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [3:0]  loss_set,
  input wire logic [3:0]  oof_set,
  input wire logic [15:0] freq_word,
  input wire logic        run,
  // monitor outputs
  output logic [3:0]      signal_loss_alarm,
  output logic [3:0]      frequency_out_of_range_alarm,
  output logic [15:0]     freq_sample,
  output logic            freq_sample_valid
);
  logic [1:0] phase_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      signal_loss_alarm <= 4'h0;
      frequency_out_of_range_alarm <= 4'h0;
    end else begin
      signal_loss_alarm <= loss_set;
      frequency_out_of_range_alarm <= oof_set;
    end
  end
  // one sample every fourth cycle; the word is scrambled between samples
  always_ff @(posedge clock) begin
    phase_reg <= (rst) ? 2'h0 : phase_reg + 2'h1;
    freq_sample_valid <= run && phase_reg == 2'h3;
    freq_sample <= (run && phase_reg == 2'h3) ? freq_word : ~freq_sample;
  end
endmodule
`default_nettype wire

// ==== test_icsh_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_icsh_ctrl
  import icsh_pkg::*;
;
  logic clock, rst, reg_wr, reg_rd, hold, fvalid, run;
  logic [15:0] reg_addr, fword, fsample, hfreq;
  logic [7:0] reg_wdata, reg_rdata, rd_val;
  logic [3:0] loss_set, oof_set, loss_a, oof_a;
  logic [1:0] select_pins, active;
  icsh_cfg_s cfg;
  int n_fail, compares, cyc, i;
  logic [15:0] addr_t [12] = '{OFS_INPUT_SELECT, OFS_AVG_LENGTH, OFS_HIST_DELAY,
    OFS_FORCE_HOLD, OFS_SWITCH_CTRL, OFS_ALARM_MASKS, OFS_PRIO_01, OFS_PRIO_23,
    OFS_REF_SOURCE, OFS_IO_VOLTAGE, OFS_INPUT_BUFFER, OFS_DIV_ROUTING};
  logic [7:0] msk_t [12] = '{8'h07, 8'h1F, 8'h1F, 8'h01, 8'h07, 8'hFF, 8'h77, 8'h77,
    8'h01, 8'h01, 8'hFF, 8'h03};
  logic [7:0] rst_t [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h43,
    8'h00, 8'h00, 8'h0F, 8'h00};
  icsh_ctrl dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .signal_loss_alarm(loss_a),
    .frequency_out_of_range_alarm(oof_a), .select_pins(select_pins),
    .freq_sample(fsample), .freq_sample_valid(fvalid), .active_input_indicator(active),
    .holdover_active(hold), .holdover_freq(hfreq), .cfg(cfg));
  icsh_ref_model ref_u (.clock(clock), .rst(rst), .loss_set(loss_set), .oof_set(oof_set),
    .freq_word(fword), .run(run), .signal_loss_alarm(loss_a),
    .frequency_out_of_range_alarm(oof_a), .freq_sample(fsample), .freq_sample_valid(fvalid));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  // read data is registered on the strobe edge, so it is settled by the next fall
  task automatic rd(input logic [15:0] a);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask
  // alarms pass a three-stage filter; eight cycles covers it with margin
  task automatic act(input logic [1:0] e);
    repeat (8) @(negedge clock);
    chk({14'h0, active}, {14'h0, e});
  endtask
  task automatic finish_test();
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    rst = 1'b1; reg_addr = 16'h0; reg_wdata = 8'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    loss_set = 4'h0; oof_set = 4'h0; select_pins = 2'h0; fword = 16'h1234; run = 1'b0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    for (i = 0; i < 12; i++) begin
      rd(addr_t[i]);
      chk({8'h0, rd_val}, {8'h0, rst_t[i]});
      wr(addr_t[i], 8'hFF);
      rd(addr_t[i]);
      chk({8'h0, rd_val}, {8'h0, msk_t[i]});
    end
    chk({3'h0, cfg}, 16'h1FFF);
    wr(OFS_ACTIVE_INPUT, 8'h00);
    rd(OFS_ACTIVE_INPUT);
    chk({8'h0, rd_val}, 16'h00C0);
    rd(16'h0000);
    chk({8'h0, rd_val}, 16'h0000);
    for (i = 0; i < 12; i++) wr(addr_t[i], rst_t[i]);
    chk({3'h0, cfg}, 16'h0F00);
    wr(OFS_AVG_LENGTH, 8'h02);
    wr(OFS_HIST_DELAY, 8'h01);
    run = 1'b1;
    repeat (200) @(negedge clock);
    chk(hfreq, 16'h1234);
    fword = 16'h7000;
    repeat (4) @(negedge clock);
    run = 1'b0;
    wr(OFS_FORCE_HOLD, 8'h01);
    repeat (8) @(negedge clock);
    chk({15'h0, hold}, 16'h0001);
    chk(hfreq, 16'h1234);
    wr(OFS_FORCE_HOLD, 8'h00);
    act(2'h0);
    chk({15'h0, hold}, 16'h0000);
    wr(OFS_PRIO_01, 8'h22);
    wr(OFS_PRIO_23, 8'h03);
    wr(OFS_SWITCH_CTRL, 8'h02);
    act(2'h0);
    loss_set = 4'h1;
    act(2'h1);
    loss_set = 4'h3;
    act(2'h2);
    wr(OFS_ALARM_MASKS, 8'h02);
    act(2'h1);
    oof_set = 4'h2;
    act(2'h2);
    wr(OFS_ALARM_MASKS, 8'h22);
    act(2'h1);
    loss_set = 4'h0;
    oof_set = 4'h0;
    act(2'h0);
    wr(OFS_SWITCH_CTRL, 8'h01);
    loss_set = 4'h1;
    act(2'h1);
    loss_set = 4'h0;
    act(2'h1);
    wr(OFS_PRIO_01, 8'h02);
    act(2'h0);
    loss_set = 4'hF;
    act(2'h0);
    chk({15'h0, hold}, 16'h0001);
    loss_set = 4'h0;
    wr(OFS_INPUT_BUFFER, 8'h0E);
    act(2'h2);
    chk({15'h0, hold}, 16'h0000);
    wr(OFS_SWITCH_CTRL, 8'h00);
    wr(OFS_INPUT_SELECT, 8'h03);
    act(2'h1);
    wr(OFS_INPUT_SELECT, 8'h00);
    select_pins = 2'h3;
    act(2'h3);
    finish_test();
  end
endmodule
`default_nettype wire
